// [rtl/cg_master_pkg.sv]
// constants for the coarse clock gating master
package cg_master_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_GATING_CONTROL  = 12'h040;
    localparam logic [11:0] OFS_FORCE_DISABLE   = 12'h044;
    localparam logic [11:0] OFS_CLOCK_KILL      = 12'h046;
    localparam logic [11:0] OFS_ALARM           = 12'h048;
    localparam logic [11:0] OFS_ORDER_LOW       = 12'h04c;
    localparam logic [11:0] OFS_ORDER_HIGH      = 12'h050;
    localparam logic [11:0] OFS_GATED_DURATION  = 12'h054;
    localparam logic [11:0] OFS_EXIT_DELAY_LOW  = 12'h05a;
    localparam logic [11:0] OFS_EXIT_DELAY_HIGH = 12'h05c;
    // gating_control field positions
    localparam int BIT_GATING_ENABLE  = 31;
    localparam int BIT_TIMEOUT_ENABLE = 30;
    localparam int BIT_SQUELCH_ENABLE = 28;
    localparam int ISO_DLY_LSB        = 16;
    localparam int ISO_DLY_W          = 5;
    localparam int IDLE_DLY_LSB       = 0;
    localparam int IDLE_DLY_W         = 10;
    // writable bits of gating_control, force disable and exit delay high, reserved bits read zero
    localparam logic [31:0] CTRL_WMASK     = 32'hd01f_03ff;
    localparam logic [15:0] FORCE_WMASK    = 16'h0fff;
    localparam logic [15:0] DLY_HIGH_WMASK = 16'h0007;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    // extra squelch path delay in clocks when the squelch delay option is on
    localparam int SQUELCH_DLY_CYC = 4;
    // controller states, gray along count->isolate->gate->gated->ungate
    typedef enum logic [2:0] {
        ST_COUNT  = 3'b000,
        ST_ISOL   = 3'b001,
        ST_GSEQ   = 3'b011,
        ST_GATED  = 3'b010,
        ST_USEQ   = 3'b110
    } cg_state_t;
endpackage

// [rtl/coarse_clock_gating_master.sv]
// coarse clock gating master: idle detect, isolate, ordered gating, alarm exit
`timescale 1ns/10ps
`default_nettype none
module coarse_clock_gating_master
#(
    parameter int SLAVES  = 12,
    parameter int DOMAINS = 16
)
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [11:0]         cfg_addr,
    input  wire logic                cfg_wr,
    input  wire logic                cfg_rd,
    input  wire logic [31:0]         cfg_wdata,
    output logic      [31:0]         cfg_rdata,
    input  wire logic [SLAVES-1:0]   slave_idle,
    input  wire logic                squelch_in,
    output logic                     squelch_out,
    output logic                     local_isolate_a,
    output logic      [DOMAINS-1:0]  master_gate,
    output logic      [DOMAINS-1:0]  domain_clock_kill,
    output logic      [18:0]         pstate_exit_delay,
    output logic                     coarse_gated_mode
);
    import cg_master_pkg::*;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [15:0] force_q;
    logic [15:0] kill_q;
    logic [31:0] alarm_q;
    logic [31:0] order_lo_q;
    logic [31:0] order_hi_q;
    logic [31:0] duration_q;
    logic [15:0] dly_lo_q;
    logic [15:0] dly_hi_q;
    cg_state_t   state_q;

    function automatic logic wr_hit(input logic [11:0] ofs);
        wr_hit = cfg_wr && (cfg_addr == ofs);
    endfunction

    // four-bit order slot of every domain matched against a sequence step
    function automatic logic [DOMAINS-1:0] step_mask(input logic [3:0] step);
        logic [63:0] ord;
        ord = {order_hi_q, order_lo_q};
        step_mask = '0;
        for (int i = 0; i < DOMAINS; i++)
        begin
            step_mask[i] = (ord[i*4 +: 4] == step);
        end
    endfunction

    // software writes, reserved bits masked so they read back zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q     <= RST_WORD;
            force_q    <= RST_HALF;
            kill_q     <= RST_HALF;
            alarm_q    <= RST_WORD;
            order_lo_q <= RST_WORD;
            order_hi_q <= RST_WORD;
            dly_lo_q   <= RST_HALF;
            dly_hi_q   <= RST_HALF;
        end
        else
        begin
            if (wr_hit(OFS_GATING_CONTROL))  ctrl_q     <= cfg_wdata & CTRL_WMASK;
            if (wr_hit(OFS_FORCE_DISABLE))   force_q    <= cfg_wdata[15:0] & FORCE_WMASK;
            if (wr_hit(OFS_CLOCK_KILL))      kill_q     <= cfg_wdata[15:0];
            if (wr_hit(OFS_ALARM))           alarm_q    <= cfg_wdata;
            if (wr_hit(OFS_ORDER_LOW))       order_lo_q <= cfg_wdata;
            if (wr_hit(OFS_ORDER_HIGH))      order_hi_q <= cfg_wdata;
            if (wr_hit(OFS_EXIT_DELAY_LOW))  dly_lo_q   <= cfg_wdata[15:0];
            if (wr_hit(OFS_EXIT_DELAY_HIGH)) dly_hi_q   <= cfg_wdata[15:0] & DLY_HIGH_WMASK;
        end
    end

    // read data registered, unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg_rdata <= RST_WORD;
        else if (cfg_rd)
        begin
            case (cfg_addr)
                OFS_GATING_CONTROL:  cfg_rdata <= ctrl_q;
                OFS_FORCE_DISABLE:   cfg_rdata <= {16'h0000, force_q};
                OFS_CLOCK_KILL:      cfg_rdata <= {16'h0000, kill_q};
                OFS_ALARM:           cfg_rdata <= alarm_q;
                OFS_ORDER_LOW:       cfg_rdata <= order_lo_q;
                OFS_ORDER_HIGH:      cfg_rdata <= order_hi_q;
                OFS_GATED_DURATION:  cfg_rdata <= duration_q;
                OFS_EXIT_DELAY_LOW:  cfg_rdata <= {16'h0000, dly_lo_q};
                OFS_EXIT_DELAY_HIGH: cfg_rdata <= {16'h0000, dly_hi_q};
                default:             cfg_rdata <= RST_WORD;
            endcase
        end
    end

    // kill mask bypasses the sequencer entirely
    assign domain_clock_kill = kill_q;
    assign pstate_exit_delay = {dly_hi_q[2:0], dly_lo_q};

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SLAVES-1:0] idle_m_q;
    logic [SLAVES-1:0] idle_s_q;
    logic              sq_m_q;
    logic              sq_s_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            idle_m_q <= '0;
            idle_s_q <= '0;
            sq_m_q   <= 1'b0;
            sq_s_q   <= 1'b0;
        end
        else
        begin
            idle_m_q <= slave_idle;
            idle_s_q <= idle_m_q;
            sq_m_q   <= squelch_in;
            sq_s_q   <= sq_m_q;
        end
    end

    // squelch delay line; a fixed depth keeps gated timing equal to normal
    logic [SQUELCH_DLY_CYC-1:0] sq_line_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sq_line_q   <= '0;
            squelch_out <= 1'b0;
        end
        else
        begin
            sq_line_q   <= {sq_line_q[SQUELCH_DLY_CYC-2:0], sq_s_q};
            squelch_out <= ctrl_q[BIT_SQUELCH_ENABLE] ? sq_line_q[SQUELCH_DLY_CYC-1]
                                                     : sq_s_q;
        end
    end

    // ------------------------------------------------------------
    // gating sequencer
    // ------------------------------------------------------------
    logic [SLAVES-1:0]    eff_idle;
    logic                 all_idle;
    logic                 alarm_hit;
    logic                 wake;
    logic [IDLE_DLY_W-1:0] idle_cnt_q;
    logic [ISO_DLY_W-1:0] iso_cnt_q;
    logic [3:0]           step_q;
    logic [31:0]          alarm_cnt_q;

    // a cleared force bit makes that slave count as idle
    assign eff_idle  = idle_s_q | ~force_q[SLAVES-1:0];
    assign all_idle  = &eff_idle;
    // alarm ends gating only once gated; a stale zero count must not abort entry
    assign alarm_hit = ctrl_q[BIT_TIMEOUT_ENABLE] && (alarm_q != RST_WORD)
                       && (state_q == ST_GATED) && (alarm_cnt_q == RST_WORD);
    assign wake      = !all_idle || alarm_hit || !ctrl_q[BIT_GATING_ENABLE];
    assign coarse_gated_mode = (state_q == ST_GATED);

    // consecutive idle counter, restarts on activity of any slave whose force bit is set, or after ungating
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            idle_cnt_q <= '0;
        else if (state_q != ST_COUNT || !all_idle)
            idle_cnt_q <= '0;
        else if (idle_cnt_q != {IDLE_DLY_W{1'b1}})
            idle_cnt_q <= idle_cnt_q + 1'b1;
    end

    // working alarm copy; the programmed value is never touched
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            alarm_cnt_q <= RST_WORD;
        else if (state_q == ST_GSEQ && step_q == 4'hf)
            alarm_cnt_q <= alarm_q;
        else if (state_q == ST_GATED && alarm_cnt_q != RST_WORD)
            alarm_cnt_q <= alarm_cnt_q - 1'b1;
    end

    // state, isolate and per-domain gates
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q         <= ST_COUNT;
            iso_cnt_q       <= '0;
            step_q          <= 4'h0;
            local_isolate_a <= 1'b0;
            master_gate     <= '0;
        end
        else
        begin
            case (state_q)
                ST_COUNT:
                begin
                    if (ctrl_q[BIT_GATING_ENABLE] && all_idle
                        && idle_cnt_q >= ctrl_q[IDLE_DLY_LSB +: IDLE_DLY_W])
                    begin
                        state_q         <= ST_ISOL;
                        local_isolate_a <= 1'b1;
                        iso_cnt_q       <= '0;
                    end
                end
                ST_ISOL:
                begin
                    if (wake)
                    begin
                        state_q         <= ST_COUNT;
                        local_isolate_a <= 1'b0;
                    end
                    else if (iso_cnt_q >= ctrl_q[ISO_DLY_LSB +: ISO_DLY_W])
                    begin
                        state_q <= ST_GSEQ;
                        step_q  <= 4'h0;
                    end
                    else
                        iso_cnt_q <= iso_cnt_q + 1'b1;
                end
                ST_GSEQ:
                begin
                    master_gate <= master_gate | step_mask(step_q);
                    if (wake)
                    begin
                        state_q <= ST_USEQ;
                        step_q  <= 4'hf;
                    end
                    else if (step_q == 4'hf)
                        state_q <= ST_GATED;
                    else
                        step_q <= step_q + 1'b1;
                end
                ST_GATED:
                begin
                    if (wake)
                    begin
                        state_q <= ST_USEQ;
                        step_q  <= 4'hf;
                    end
                end
                ST_USEQ:
                begin
                    master_gate <= master_gate & ~step_mask(step_q);
                    if (step_q == 4'h0)
                    begin
                        state_q         <= ST_COUNT;
                        local_isolate_a <= 1'b0;
                    end
                    else
                        step_q <= step_q - 1'b1;
                end
                default:
                begin
                    state_q         <= ST_COUNT;
                    local_isolate_a <= 1'b0;
                    master_gate     <= '0;
                end
            endcase
        end
    end

    // gated-duration counter; hardware count wins over a same-cycle write
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            duration_q <= RST_WORD;
        else if (state_q == ST_GATED)
            duration_q <= duration_q + 1'b1;
        else if (wr_hit(OFS_GATED_DURATION))
            duration_q <= cfg_wdata;
    end
endmodule
`default_nettype wire

// [test/cg_master_checker.sv]
// concurrent checks on the ports of the coarse clock gating master
`timescale 1ns/10ps
`default_nettype none
module cg_master_checker
#(
    parameter int SLAVES  = 12,
    parameter int DOMAINS = 16
)
(
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic [11:0]        cfg_addr,
    input wire logic               cfg_wr,
    input wire logic [31:0]        cfg_wdata,
    input wire logic [SLAVES-1:0]  slave_idle,
    input wire logic               squelch_in,
    input wire logic               squelch_out,
    input wire logic               local_isolate_a,
    input wire logic [DOMAINS-1:0] master_gate,
    input wire logic [DOMAINS-1:0] domain_clock_kill,
    input wire logic [18:0]        pstate_exit_delay,
    input wire logic               coarse_gated_mode
);
    import cg_master_pkg::*;
    logic [31:0] ctl_q;
    logic [31:0] alm_q;
    logic [31:0] run_q;
    logic [15:0] frc_q;
    logic        eff;
    // shadow of the programmed fields, masked the way the block keeps them
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctl_q <= '0;
            alm_q <= '0;
            frc_q <= '0;
        end
        else if (cfg_wr)
        begin
            if (cfg_addr == OFS_GATING_CONTROL)
                ctl_q <= cfg_wdata & CTRL_WMASK;
            if (cfg_addr == OFS_ALARM)
                alm_q <= cfg_wdata;
            if (cfg_addr == OFS_FORCE_DISABLE)
                frc_q <= cfg_wdata[15:0];
        end
    end
    // length of the current gated stretch, zero outside it
    always_ff @(posedge clk)
        run_q <= (!rst_n || !coarse_gated_mode) ? 32'h0 : run_q + 32'h1;
    // a slave with its force bit cleared counts as idle whatever it reports
    assign eff = &(slave_idle | ~frc_q[SLAVES-1:0]);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_EN_GATE: assert property ($rose(local_isolate_a) |-> $past(ctl_q[BIT_GATING_ENABLE]))
        else $error("isolate rose while gating disabled");
    AST_ALARM: assert property (coarse_gated_mode && ctl_q[30] && alm_q != 0
        |-> run_q <= alm_q + 32'h1) else $error("gated stretch outlived alarm");
    AST_SQL: assert property ((!ctl_q[28] && squelch_in)[*6] |-> squelch_out)
        else $error("squelch did not follow input");
    AST_ISO_LEAD: assert property ($rose(local_isolate_a) |-> (master_gate == '0)[*2])
        else $error("gate came without isolate lead");
    AST_ISO_GATE: assert property (master_gate != '0 |-> local_isolate_a)
        else $error("domain gated without isolate");
    AST_FULL: assert property (coarse_gated_mode |-> master_gate == '1)
        else $error("gated mode with open domains");
    AST_KILL: assert property (cfg_wr && cfg_addr == OFS_CLOCK_KILL
        |=> domain_clock_kill == $past(cfg_wdata[15:0])) else $error("kill mask not applied");
    AST_DLY_LO: assert property (cfg_wr && cfg_addr == OFS_EXIT_DELAY_LOW
        |=> pstate_exit_delay[15:0] == $past(cfg_wdata[15:0])) else $error("delay low wrong");
    AST_DLY_HI: assert property (cfg_wr && cfg_addr == OFS_EXIT_DELAY_HIGH
        |=> pstate_exit_delay[18:16] == $past(cfg_wdata[2:0])) else $error("delay high wrong");
    AST_WAKE: assert property (coarse_gated_mode && !eff |-> ##[1:6] !coarse_gated_mode)
        else $error("activity did not end gating");
    cover property ($rose(coarse_gated_mode));
    cover property ($fell(local_isolate_a));
    cover property (domain_clock_kill != '0);
endmodule
bind coarse_clock_gating_master cg_master_checker #(.SLAVES(SLAVES), .DOMAINS(DOMAINS))
    cg_master_checker_inst (.clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .slave_idle(slave_idle), .squelch_in(squelch_in),
    .squelch_out(squelch_out), .local_isolate_a(local_isolate_a), .master_gate(master_gate),
    .domain_clock_kill(domain_clock_kill), .pstate_exit_delay(pstate_exit_delay),
    .coarse_gated_mode(coarse_gated_mode));
`default_nettype wire

// [test/slave_model.sv]
// behavioural slave controllers reporting idle to the master
`timescale 1ns/10ps
`default_nettype none
module slave_model
(
    input  wire logic        clk,
    input  wire logic [11:0] busy,
    output logic      [11:0] slave_idle
);
    logic [11:0] b1_q;
    // two-clock reaction, so the master never sees activity instantly
    always_ff @(posedge clk)
    begin
        b1_q <= busy;
        slave_idle <= ~b1_q;
    end
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the coarse clock gating master
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
    import cg_master_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    row_t        rows[10];
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, sq = 0, log = 0;
    logic [11:0] addr = '0, busy = '0, idle;
    logic [31:0] wd = '0, rdat, rda;
    logic [15:0] gate, kill, gp = '0, gx, gq[$];
    logic [18:0] pdly;
    logic        iso, sqo, mode;
    logic [2:0]  mon;
    int          err_total, check_count, glen, wn, l0;
    coarse_clock_gating_master coarse_clock_gating_master_inst (.clk(clk), .rst_n(rst_n),
        .cfg_addr(addr), .cfg_wr(wr), .cfg_rd(rd), .cfg_wdata(wd), .cfg_rdata(rda),
        .slave_idle(idle), .squelch_in(sq), .squelch_out(sqo), .local_isolate_a(iso),
        .master_gate(gate), .domain_clock_kill(kill), .pstate_exit_delay(pdly),
        .coarse_gated_mode(mode));
    slave_model slave_model_inst (.clk(clk), .busy(busy), .slave_idle(idle));
    // polled outputs: 0 isolate, 1 gated mode, 2 squelch
    assign mon = {sqo, mode, iso};
    always #2.5 clk = ~clk;
    // log of gate changes and count of gated cycles since glen was last cleared
    always @(posedge clk)
    begin
        gp <= gate;
        if (log && gq.size() < 32 && gate !== gp)
            gq.push_back(gate);
        if (mode === 1'b1)
            glen <= glen + 1;
    end
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        addr = a;
        wd = d;
        wr = 1;
        @(posedge clk);
        #1 wr = 0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        addr = a;
        rd = 1;
        @(posedge clk);
        #1 rd = 0;
        @(posedge clk);
        #1 rdat = rda;
    endtask
    // bounded wait, the cycles spent are left in wn
    task automatic wt(input int s, input logic v, input int lim);
        wn = 0;
        while (mon[s] !== v && wn < lim)
        begin
            @(posedge clk);
            #1 wn++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        rows = '{'{OFS_GATING_CONTROL, 32'h7fff_ffff, 32'h501f_03ff},
            '{OFS_FORCE_DISABLE, 32'h0000_ffff, 32'h0000_0fff},
            '{OFS_CLOCK_KILL, 32'h0000_a5c3, 32'h0000_a5c3},
            '{OFS_ALARM, 32'h1234_5678, 32'h1234_5678},
            '{OFS_ORDER_LOW, 32'h7654_3210, 32'h7654_3210},
            '{OFS_ORDER_HIGH, 32'hfedc_ba98, 32'hfedc_ba98},
            '{OFS_GATED_DURATION, 32'h0000_ffff, 32'h0000_ffff},
            '{OFS_EXIT_DELAY_LOW, 32'h0000_beef, 32'h0000_beef},
            '{OFS_EXIT_DELAY_HIGH, 32'h0000_ffff, 32'h0000_0007},
            '{12'h060, 32'hffff_ffff, 32'h0000_0000}};
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a);
            `CHK(rdat, rows[i].e)
        end
        `CHK(pdly, 19'h7_beef)
        `CHK(kill, 16'ha5c3)
        $display("register rows done");
        rst_n = 0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        foreach (rows[i])
        begin
            rd_reg(rows[i].a);
            `CHK(rdat, 32'h0)
        end
        wt(0, 1'b1, 60);
        `CHK(iso, 1'b0)
        $display("reset values done");
        sq = 1;
        wt(2, 1'b1, 20);
        l0 = wn;
        // hold squelch long enough for the follow check to see six clocks
        repeat (6) @(posedge clk);
        #1 wr_reg(OFS_GATING_CONTROL, 32'h1000_0000);
        sq = 0;
        wt(2, 1'b0, 20);
        `CHK(wn - l0, SQUELCH_DLY_CYC)
        $display("squelch done");
        wr_reg(OFS_FORCE_DISABLE, 32'h1);
        busy = 12'h1;
        wr_reg(OFS_ORDER_LOW, 32'h89ab_cdef);
        wr_reg(OFS_ORDER_HIGH, 32'h0123_4567);
        wr_reg(OFS_ALARM, 32'h32);
        wr_reg(OFS_GATING_CONTROL, 32'hc003_0014);
        log = 1;
        glen = 0;
        repeat (40) @(posedge clk);
        #1 `CHK(iso, 1'b0)
        busy = 12'h0;
        wt(0, 1'b1, 60);
        `CHK(wn > 20 && wn < 31, 1'b1)
        repeat (4) @(posedge clk);
        #1 `CHK(gate, 16'h0)
        @(posedge clk);
        #1 `CHK(gate, 16'h8000)
        wt(1, 1'b1, 40);
        wt(1, 1'b0, 100);
        `CHK(glen > 49 && glen < 53, 1'b1)
        rd_reg(OFS_GATED_DURATION);
        `CHK(rdat, 32'(glen))
        wt(0, 1'b0, 40);
        // the change log lags the gates by one clock, let the last entry land
        @(posedge clk);
        #1 `CHK(gq.size(), 32)
        for (int j = 0; j < 32; j++)
        begin
            gx = j < 16 ? 16'hffff << (15 - j) : 16'hffff << (j - 15);
            `CHK(gq[j], gx)
        end
        $display("ordered gating done");
        wr_reg(OFS_GATING_CONTROL, 32'h8003_0014);
        wt(1, 1'b1, 100);
        repeat (200) @(posedge clk);
        #1 `CHK(mode, 1'b1)
        busy = 12'h1;
        wt(0, 1'b0, 60);
        `CHK(gate, 16'h0)
        repeat (60) @(posedge clk);
        #1 `CHK(iso, 1'b0)
        wr_reg(OFS_FORCE_DISABLE, 32'h0);
        wt(1, 1'b1, 100);
        `CHK(mode, 1'b1)
        wr_reg(OFS_GATING_CONTROL, 32'h0);
        wt(0, 1'b0, 100);
        `CHK(gate, 16'h0)
        $display("wake and force done");
        test_done();
    end
    // the whole run needs well under 10 us
    initial
    begin
        #50000;
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
